/* File: pkg/supervisor_pkg.sv */
package supervisor_pkg;

   // =========================================================
   // Clock and time base
   localparam int CLK_HZ = 125_000_000;
   localparam int TB_FREQ_CHZ = 1_024_000;
   localparam int TICK_DIV = CLK_HZ / (TB_FREQ_CHZ / 100);
   localparam int DIV_W = 14;

   // =========================================================
   // Durations in the internal oscillator mode
   localparam int RST_PULSE_MS = 50;
   localparam int WD_SHORT_MS = 100;
   localparam int WD_LONG_MS = 1600;
   localparam int CNT_W = 15;
   localparam logic [CNT_W-1:0] INT_RST_TICKS =
      CNT_W'(RST_PULSE_MS * (TB_FREQ_CHZ / 100) / 1000);
   localparam logic [CNT_W-1:0] INT_SHORT_TICKS =
      CNT_W'(WD_SHORT_MS * (TB_FREQ_CHZ / 100) / 1000);
   localparam logic [CNT_W-1:0] INT_LONG_TICKS =
      CNT_W'(WD_LONG_MS * (TB_FREQ_CHZ / 100) / 1000);

   // =========================================================
   // Durations with an external clock
   localparam logic [CNT_W-1:0] EXT_RST_CLKS = 15'h0200;
   localparam logic [CNT_W-1:0] EXT_NORMAL_CLKS = 15'h0400;
   localparam logic [CNT_W-1:0] EXT_LONG_CLKS = 15'h1000;

   // =========================================================
   // Synchroniser lanes
   localparam int SYNC_W = 5;
   localparam int LN_LOW_LINE = 0;
   localparam int LN_POWER_FAIL = 1;
   localparam int LN_BELOW_BACKUP = 2;
   localparam int LN_STROBE = 3;
   localparam int LN_TB_INPUT = 4;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

   // =========================================================
   // Supervisor states
   typedef enum logic [1:0] {
      ST_PULSE,
      ST_LOWLINE,
      ST_RUN
   } sup_state_t;

endpackage

/* File: rtl/sync_stage.sv */
`timescale 1ns/1ns
module sync_stage (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic [supervisor_pkg::SYNC_W-1:0] async_in,
   output logic [supervisor_pkg::SYNC_W-1:0] sync_out
);
   import supervisor_pkg::*;

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;

   // =========================================================
   // Two flip-flop synchroniser
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= SYNC_RESET;
         sync_q <= SYNC_RESET;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // sync_stage

/* File: rtl/timebase_tick.sv */
`timescale 1ns/1ns
module timebase_tick #(
   parameter int DIV = supervisor_pkg::TICK_DIV
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic internal_in,
   input wire logic ext_level_in,
   output logic tick_out
);
   import supervisor_pkg::*;

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic ext_prev_q;
   logic div_wrap;
   logic ext_rise;

   // =========================================================
   // Internal divider and external edge
   assign div_wrap = (div_q == DIV_W'(DIV - 1));
   assign div_d = div_wrap ? '0 : div_q + 1'b1;
   assign ext_rise = ext_level_in & ~ext_prev_q;
   assign tick_out = internal_in ? div_wrap : ext_rise;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_q <= '0;
         ext_prev_q <= 1'b0;
      end else begin
         div_q <= div_d;
         ext_prev_q <= ext_level_in;
      end
   end

endmodule // timebase_tick

/* File: rtl/supervisor_watchdog_ce_gate.sv */
// Notes on behaviour
// RULE1 - Low line above threshold: gated chip enable follows its input.
// RULE2 - Below low-line threshold, gated chip enable is forced high.
// RULE3 - Gated chip enable also forced high while supply is below battery.
// RULE4 - Power-fail flag low when power-fail sense is low, else high.
// RULE5 - Supply below battery holds power-fail flag low.
// RULE6 - No strobe toggle within timeout gives a reset pulse of set width.
// RULE7 - Long timeout after reset until first strobe edge after reset ends.
// RULE8 - Watchdog count restarts at the end of every reset.
// RULE9 - Stuck strobe gives a reset pulse every post-reset timeout period.
// RULE10 - Floating strobe disables the watchdog entirely.
// RULE11 - Timeout drives fault low until the next strobe transition.
// RULE12 - Fault output set high while low-line sense is low.
// RULE13 - Internal oscillator mode: timebase input picks 1.6 s or 100 ms.
// RULE14 - Internal mode uses 1.6 s right after any reset.
// RULE15 - Strobe transitions during reset are ignored.
// RULE16 - 100 ms normal timeout only after first strobe edge past reset.
// RULE17 - External clock: 1024 normal, 4096 post-reset, 512 reset width.
// RULE18 - Processor leaves strobe idle during init, then toggles under 70 ms.
// RULE19 - Reset held during low line and pulse width after recovery.
// RULE20 - Active-high reset output is inverse of active-low reset.
// RULE21 - Internal mode counts a 10.24 kHz time base.
// RULE22 - Comparator results are synchronised before use.
// RULE23 - Both strobe edges count as watchdog service.
// RULE24 - Low-line output low while low-line sense is below threshold.
`timescale 1ns/1ns
module supervisor_watchdog_ce_gate #(
   parameter int TICK_DIV_P = supervisor_pkg::TICK_DIV
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic low_line_sense_low_in,
   input wire logic power_fail_sense_low_in,
   input wire logic below_backup_supply_level_in,
   input wire logic ce_n_in,
   input wire logic watchdog_strobe_in,
   input wire logic watchdog_strobe_float_in,
   input wire logic timebase_select_in,
   input wire logic timebase_input_in,
   input wire logic timebase_input_float_in,
   output logic ce_n_out,
   output logic power_fail_flag_n_out,
   output logic watchdog_fault_n_out,
   output logic reset_n_out,
   output logic reset_out,
   output logic low_line_n_out
);
   import supervisor_pkg::*;

   // =========================================================
   // Declarations
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic low_line_s;
   logic power_fail_s;
   logic below_backup_s;
   logic strobe_s;
   logic tb_input_s;
   logic internal_mode;
   logic tick;
   logic strobe_prev_q;
   logic strobe_edge;
   logic hold_reset;
   logic short_select;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] pulse_len;
   logic pulse_done;
   logic wd_expire;
   sup_state_t state_q;
   sup_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic long_q;
   logic long_d;
   logic fault_n_q;
   logic fault_n_d;
   logic ce_block;
   logic ce_n_q;
   logic pf_n_q;
   logic rst_n_q;
   logic ll_n_q;

   // =========================================================
   // Timeout selection by mode
   function automatic logic [CNT_W-1:0] timeout_limit(
      input logic internal,
      input logic post_reset,
      input logic short_sel
   );
      logic [CNT_W-1:0] lim;
      lim = EXT_NORMAL_CLKS;
      if (internal) begin
         if (post_reset || !short_sel) begin
            lim = INT_LONG_TICKS; // [RULE14]
         end else begin
            lim = INT_SHORT_TICKS; // [RULE16]
         end
      end else if (post_reset) begin
         lim = EXT_LONG_CLKS; // [RULE17]
      end
      return lim;
   endfunction

   // =========================================================
   // Input synchronisation
   assign raw_in[LN_LOW_LINE] = low_line_sense_low_in;
   assign raw_in[LN_POWER_FAIL] = power_fail_sense_low_in;
   assign raw_in[LN_BELOW_BACKUP] = below_backup_supply_level_in;
   assign raw_in[LN_STROBE] = watchdog_strobe_in;
   assign raw_in[LN_TB_INPUT] = timebase_input_in;

   sync_stage u_sync ( // [RULE22]
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   assign low_line_s = sync_in[LN_LOW_LINE];
   assign power_fail_s = sync_in[LN_POWER_FAIL];
   assign below_backup_s = sync_in[LN_BELOW_BACKUP];
   assign strobe_s = sync_in[LN_STROBE];
   assign tb_input_s = sync_in[LN_TB_INPUT];

   // =========================================================
   // Time base
   assign internal_mode = timebase_select_in;

   timebase_tick #(
      .DIV(TICK_DIV_P)
   ) u_tick ( // [RULE21]
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .internal_in(internal_mode),
      .ext_level_in(tb_input_s),
      .tick_out(tick)
   );

   // =========================================================
   // Decoding
   assign strobe_edge = strobe_s ^ strobe_prev_q; // [RULE23]
   assign hold_reset = low_line_s | below_backup_s; // [RULE19]
   assign ce_block = low_line_s | below_backup_s; // [RULE2] [RULE3]
   assign short_select = ~tb_input_s & ~timebase_input_float_in; // [RULE13]
   assign limit = timeout_limit(internal_mode, long_q, short_select);
   assign pulse_len = internal_mode ? INT_RST_TICKS : EXT_RST_CLKS;
   assign pulse_done = tick & (cnt_q == pulse_len - 1'b1); // [RULE6]
   assign wd_expire = tick & (cnt_q == limit - 1'b1);

   // =========================================================
   // Supervisor sequence
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      long_d = long_q;
      fault_n_d = fault_n_q;
      if (hold_reset) begin
         state_d = ST_LOWLINE; // [RULE19]
         cnt_d = '0;
         long_d = 1'b1;
         fault_n_d = 1'b1; // [RULE12]
      end else begin
         case (state_q)
            ST_LOWLINE: begin
               state_d = ST_PULSE; // [RULE19]
               cnt_d = '0;
            end
            ST_PULSE: begin
               // Strobe edges have no effect here [RULE15]
               if (pulse_done) begin
                  state_d = ST_RUN;
                  cnt_d = '0; // [RULE8]
                  long_d = 1'b1; // [RULE7]
               end else if (tick) begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            ST_RUN: begin
               if (watchdog_strobe_float_in) begin
                  cnt_d = '0; // [RULE10]
                  fault_n_d = 1'b1;
               end else if (strobe_edge) begin
                  cnt_d = '0;
                  long_d = 1'b0; // [RULE7]
                  fault_n_d = 1'b1; // [RULE11]
               end else if (wd_expire) begin
                  state_d = ST_PULSE; // [RULE6] [RULE9]
                  cnt_d = '0;
                  long_d = 1'b1;
                  fault_n_d = 1'b0; // [RULE11]
               end else if (tick) begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            default: begin
               state_d = ST_PULSE;
               cnt_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ST_PULSE;
         cnt_q <= '0;
         long_q <= 1'b1;
         fault_n_q <= 1'b1;
         strobe_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         long_q <= long_d;
         fault_n_q <= fault_n_d;
         strobe_prev_q <= strobe_s;
      end
   end

   // =========================================================
   // Output flags
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ce_n_q <= 1'b1;
         pf_n_q <= 1'b0;
         rst_n_q <= 1'b0;
         ll_n_q <= 1'b0;
      end else begin
         ce_n_q <= ce_n_in | ce_block; // [RULE1]
         pf_n_q <= ~power_fail_s & ~below_backup_s; // [RULE4] [RULE5]
         rst_n_q <= (state_d == ST_RUN); // [RULE19]
         ll_n_q <= ~low_line_s; // [RULE24]
      end
   end

   assign ce_n_out = ce_n_q;
   assign power_fail_flag_n_out = pf_n_q;
   assign watchdog_fault_n_out = fault_n_q;
   assign reset_n_out = rst_n_q;
   assign reset_out = ~rst_n_q; // [RULE20]
   assign low_line_n_out = ll_n_q;

endmodule // supervisor_watchdog_ce_gate

/* File: verif/supervisor_properties.sv */
`timescale 1ns/1ns
// ==========
// Port checker
module supervisor_checker #(
   parameter int TICK_DIV_P = supervisor_pkg::TICK_DIV
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic low_line_sense_low_in,
   input wire logic power_fail_sense_low_in,
   input wire logic below_backup_supply_level_in,
   input wire logic ce_n_in,
   input wire logic watchdog_strobe_in,
   input wire logic watchdog_strobe_float_in,
   input wire logic timebase_select_in,
   input wire logic timebase_input_in,
   input wire logic timebase_input_float_in,
   input wire logic ce_n_out,
   input wire logic power_fail_flag_n_out,
   input wire logic watchdog_fault_n_out,
   input wire logic reset_n_out,
   input wire logic reset_out,
   input wire logic low_line_n_out
);
   wire ll = low_line_sense_low_in;
   wire bb = below_backup_supply_level_in;
   wire fl = watchdog_strobe_float_in;
   wire pf = power_fail_sense_low_in;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in);
   property p_ce; (!ll && !bb)[*4] |=> ce_n_out == $past(ce_n_in); endproperty
   a_ce: assert property (p_ce) else $error("enable not passed");
   property p_blk; (ll || bb)[*3] |=> ce_n_out; endproperty
   a_blk: assert property (p_blk) else $error("enable open");
   property p_pf; (pf || bb)[*3] |=> !power_fail_flag_n_out; endproperty
   a_pf: assert property (p_pf) else $error("flag high");
   property p_inv; reset_out == !reset_n_out; endproperty
   a_inv: assert property (p_inv) else $error("reset pair");
   property p_ll;
      ll[*3] |=> !reset_n_out && watchdog_fault_n_out && !low_line_n_out;
   endproperty
   a_ll: assert property (p_ll) else $error("low line");
   property p_lln; (!ll)[*3] |=> low_line_n_out; endproperty
   a_lln: assert property (p_lln) else $error("line flag");
   property p_wdf;
      $fell(watchdog_fault_n_out) |-> $fell(reset_n_out);
   endproperty
   a_wdf: assert property (p_wdf) else $error("fault");
   property p_hold;
      (!ll && !bb && !fl && $stable(watchdog_strobe_in))[*4] ##0
         !watchdog_fault_n_out |=> !watchdog_fault_n_out;
   endproperty
   a_hold: assert property (p_hold) else $error("fault cleared");
   property p_float;
      (fl && !ll && !bb)[*4] ##0 reset_n_out |=>
         reset_n_out && watchdog_fault_n_out;
   endproperty
   a_float: assert property (p_float) else $error("float trip");
endmodule // supervisor_checker
bind supervisor_watchdog_ce_gate supervisor_checker #(
   .TICK_DIV_P(TICK_DIV_P)
) u_chk (
   .sys_clk_in(sys_clk_in),
   .nrst_in(nrst_in),
   .low_line_sense_low_in(low_line_sense_low_in),
   .power_fail_sense_low_in(power_fail_sense_low_in),
   .below_backup_supply_level_in(below_backup_supply_level_in),
   .ce_n_in(ce_n_in),
   .watchdog_strobe_in(watchdog_strobe_in),
   .watchdog_strobe_float_in(watchdog_strobe_float_in),
   .timebase_select_in(timebase_select_in),
   .timebase_input_in(timebase_input_in),
   .timebase_input_float_in(timebase_input_float_in),
   .ce_n_out(ce_n_out),
   .power_fail_flag_n_out(power_fail_flag_n_out),
   .watchdog_fault_n_out(watchdog_fault_n_out),
   .reset_n_out(reset_n_out),
   .reset_out(reset_out),
   .low_line_n_out(low_line_n_out)
);

/* File: verif/cpu_strobe_model.sv */
`timescale 1ns/1ns
// ==========
// Processor strobe model
module cpu_strobe_model (
   input wire logic sys_clk_in,
   input wire logic run_in,
   output logic strobe_out = 1'b0
);
   logic [6:0] gap_q = 7'h00;
   always @(posedge sys_clk_in) begin
      gap_q <= run_in ? gap_q + 7'h01 : 7'h00;
      // Idle until told, then well inside the short period
      if (run_in && gap_q == 7'h7f) begin
         strobe_out <= ~strobe_out;
      end
   end
endmodule // cpu_strobe_model

/* File: verif/tb_supervisor_watchdog_ce_gate.sv */
`timescale 1ns/1ns
// ==========
// Supervisor bench
module tb_supervisor_watchdog_ce_gate;
   logic sys_clk_in = 1'b0, nrst_in = 1'b0, ce_n_in = 1'b1;
   logic low_line_sense_low_in = 1'b0, power_fail_sense_low_in = 1'b0;
   logic below_backup_supply_level_in = 1'b0, watchdog_strobe_in;
   logic watchdog_strobe_float_in = 1'b0, timebase_select_in = 1'b0;
   logic timebase_input_in = 1'b0, timebase_input_float_in = 1'b0;
   logic ce_n_out, power_fail_flag_n_out, watchdog_fault_n_out;
   logic reset_n_out, reset_out, low_line_n_out;
   logic run = 1'b0, ext_en = 1'b1, watch = 1'b0, rst_q = 1'b0, stb_q = 1'b0;
   int errors = 0, check_count = 0, seed = 12, cycles = 0, since = 0, lo, hi;
   int lo_q[$], hi_q[$];
   supervisor_watchdog_ce_gate #(
      .TICK_DIV_P(4)
   ) u_dut (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .low_line_sense_low_in(low_line_sense_low_in),
      .power_fail_sense_low_in(power_fail_sense_low_in),
      .below_backup_supply_level_in(below_backup_supply_level_in),
      .ce_n_in(ce_n_in),
      .watchdog_strobe_in(watchdog_strobe_in),
      .watchdog_strobe_float_in(watchdog_strobe_float_in),
      .timebase_select_in(timebase_select_in),
      .timebase_input_in(timebase_input_in),
      .timebase_input_float_in(timebase_input_float_in),
      .ce_n_out(ce_n_out),
      .power_fail_flag_n_out(power_fail_flag_n_out),
      .watchdog_fault_n_out(watchdog_fault_n_out),
      .reset_n_out(reset_n_out),
      .reset_out(reset_out),
      .low_line_n_out(low_line_n_out)
   );
   cpu_strobe_model u_cpu (
      .sys_clk_in(sys_clk_in),
      .run_in(run),
      .strobe_out(watchdog_strobe_in)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic note(input int l, input int h);
      lo_q.push_back(l);
      hi_q.push_back(h);
   endtask
   task automatic wait_rst(input int n);
      repeat (n) @(reset_n_out);
      @(posedge sys_clk_in);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always #4 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      timebase_input_in <= ext_en & ~timebase_input_in;
   end
   // Watcher: cycles since the last reset edge or, with reset high, the last strobe edge, against the oldest note
   always @(posedge sys_clk_in) begin
      rst_q <= reset_n_out;
      stb_q <= watchdog_strobe_in;
      since <= since + 1;
      if (rst_q !== reset_n_out) begin
         since <= 1;
         if (watch) begin
            lo = (lo_q.size() > 0) ? lo_q.pop_front() : 0;
            hi = (hi_q.size() > 0) ? hi_q.pop_front() : 0;
            check((since >= lo && since <= hi) ? lo : since, lo);
         end
      end else if (reset_n_out && stb_q !== watchdog_strobe_in) begin
         since <= 1;
      end
      if (!nrst_in) since <= 0;
   end
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 96000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      note(1024, 1040);
      note(8192, 8192);
      note(1024, 1024);
      note(2048, 2060);
      note(1024, 1024);
      repeat (20) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      watch <= 1'b1;
      run <= 1'b1;
      repeat (300) @(posedge sys_clk_in);
      run <= 1'b0;
      wait_rst(3);
      run <= 1'b1;
      repeat (150) @(posedge sys_clk_in);
      watchdog_strobe_float_in <= 1'b1;
      repeat (200) @(posedge sys_clk_in);
      watchdog_strobe_float_in <= 1'b0;
      repeat (250) @(posedge sys_clk_in);
      run <= 1'b0;
      wait_rst(2);
      watch <= 1'b0;
      repeat (200) begin
         @(posedge sys_clk_in);
         {low_line_sense_low_in, power_fail_sense_low_in} <= 2'($random(seed));
         {below_backup_supply_level_in, ce_n_in} <= 2'($random(seed));
      end
      {low_line_sense_low_in, power_fail_sense_low_in} <= 2'h0;
      below_backup_supply_level_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      wait (reset_n_out === 1'b1);
      repeat (2) @(posedge sys_clk_in);
      note(1, 99999);
      note(1120, 1140);
      watch <= 1'b1;
      low_line_sense_low_in <= 1'b1;
      repeat (100) @(posedge sys_clk_in);
      low_line_sense_low_in <= 1'b0;
      wait_rst(1);
      watch <= 1'b0;
      nrst_in <= 1'b0;
      ext_en <= 1'b0;
      timebase_select_in <= 1'b1;
      repeat (20) @(posedge sys_clk_in);
      note(2048, 2064);
      note(4096, 4112);
      note(2048, 2048);
      note(65536, 65536);
      note(2048, 2048);
      nrst_in <= 1'b1;
      watch <= 1'b1;
      wait_rst(1);
      run <= 1'b1;
      repeat (300) @(posedge sys_clk_in);
      run <= 1'b0;
      wait_rst(4);
      @(posedge sys_clk_in);
      check(lo_q.size(), 0);
      check(watchdog_fault_n_out, 1'b0);
      check(reset_out, 1'b0);
      check(ce_n_out, ce_n_in);
      check(power_fail_flag_n_out, 1'b1);
      check(low_line_n_out, 1'b1);
      close_out();
   end
endmodule // tb_supervisor_watchdog_ce_gate
